/* psm_pkg.sv */
package psm_pkg;

	typedef enum logic [1:0]
	{
		PSM_FULL  = 2'h0,
		PSM_STBY  = 2'h1,
		PSM_OFF   = 2'h3
	} psm_state_t;

	// Host write word: requested state, configuration and pending-bit clears.
	typedef struct packed
	{
		logic [1:0] req_state;
		logic       link_core_en;
		logic       hpd_irq_en;
		logic       rsense_irq_en;
		logic [1:0] clr_pend;
	} psm_ctrl_t;

	// Enables handed to the rest of the transmitter.
	typedef struct packed
	{
		logic av_pipe;
		logic cfg_if;
		logic cec;
		logic gpio;
		logic ddc;
		logic link_core;
		logic clk_run;
	} psm_enables_t;

	// Read-back word for polling.
	typedef struct packed
	{
		logic [1:0] state;
		logic       link_core_en;
		logic       hpd_irq_en;
		logic       rsense_irq_en;
		logic [1:0] pend;
	} psm_status_t;

	localparam int unsigned    PSM_SYNC_STAGES   = 2;
	localparam logic [1:0]     PSM_STRAP_WAIT    = 2'h2;
	localparam int unsigned    PSM_PEND_HPD      = 0;
	localparam int unsigned    PSM_PEND_RSENSE   = 1;
	localparam logic [7:0]     PSM_ADDR_SEL_LOW  = 8'h72;
	localparam logic [7:0]     PSM_ADDR_SEL_HIGH = 8'h76;
	localparam psm_state_t     PSM_RST_STATE     = PSM_FULL;
	localparam logic           PSM_RST_LINK_EN   = 1'b0;
	localparam logic           PSM_RST_HPD_EN    = 1'b0;
	localparam logic           PSM_RST_RSENSE_EN = 1'b0;
	localparam psm_enables_t   PSM_RST_ENABLES   = '{default: 1'b1, link_core: 1'b0};

endpackage

/* psm_sync.sv */
`timescale 1ns/100ps
module psm_sync
	import psm_pkg::*;
#(
	parameter int unsigned WIDTH = 1
)
(
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second one.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule // psm_sync

/* psm_power_state_manager.sv */
`timescale 1ns/100ps
module psm_power_state_manager
	import psm_pkg::*;
(
	input  wire logic    core_clk,
	input  wire logic    rst,
	input  wire logic    cfg_req,
	input  wire logic    cfg_we,
	input  psm_ctrl_t    cfg_wdata,
	input  wire logic    slave_addr_select_pin,
	input  wire logic    hpd_pin,
	input  wire logic    rsense_pin,
	output logic         cfg_ack,
	output psm_status_t  cfg_rdata,
	output logic [7:0]   slave_addr,
	output psm_enables_t enables,
	output psm_state_t   state_out,
	output logic         irq_out
);

	psm_state_t   state_reg;
	psm_state_t   state_next;
	logic         link_en_reg;
	logic         hpd_en_reg;
	logic         rsense_en_reg;
	logic [1:0]   pend_reg;
	logic [1:0]   pend_next;
	logic [1:0]   strap_cnt_reg;
	logic         strap_done_reg;
	logic [2:0]   pins_sync;
	logic         hpd_prev_reg;
	logic         rsense_prev_reg;
	logic         hpd_event;
	logic         rsense_event;
	logic         wr_ok;
	logic         in_off;

	psm_sync #(
		.WIDTH (3)
	) u_pin_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in ({rsense_pin, hpd_pin, slave_addr_select_pin}),
		.sync_out (pins_sync)
	);

	assign in_off = (state_reg == PSM_OFF);
	assign wr_ok  = cfg_req && cfg_we && !in_off;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			hpd_prev_reg    <= 1'b0;
			rsense_prev_reg <= 1'b0;
		end
		else
		begin
			hpd_prev_reg    <= pins_sync[1];
			rsense_prev_reg <= pins_sync[2];
		end
	end

	// Any change of the hot-plug level after the strap has been taken counts as a hot-plug event.
	assign hpd_event    = (pins_sync[1] != hpd_prev_reg) && strap_done_reg;
	assign rsense_event = (pins_sync[2] != rsense_prev_reg) && strap_done_reg;

	// State selection; off is left only through rst.
	always_comb
	begin
		state_next = state_reg;
		if (wr_ok)
		begin
			case (cfg_wdata.req_state)
				PSM_FULL: state_next = PSM_FULL;
				PSM_STBY: state_next = PSM_STBY;
				PSM_OFF:  state_next = PSM_OFF;
				default:  state_next = state_reg;
			endcase
		end
		if (in_off)
			state_next = PSM_OFF;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			state_reg <= PSM_RST_STATE;
		else
			state_reg <= state_next;
	end

	// Configuration is frozen once off is entered.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			link_en_reg   <= PSM_RST_LINK_EN;
			hpd_en_reg    <= PSM_RST_HPD_EN;
			rsense_en_reg <= PSM_RST_RSENSE_EN;
		end
		else if (wr_ok)
		begin
			link_en_reg   <= cfg_wdata.link_core_en;
			hpd_en_reg    <= cfg_wdata.hpd_irq_en;
			rsense_en_reg <= cfg_wdata.rsense_irq_en;
		end
	end

	// Sticky pending bits; a new event wins over a clear in the same cycle.
	always_comb
	begin
		pend_next = pend_reg;
		if (wr_ok)
			pend_next = pend_reg & ~cfg_wdata.clr_pend;
		if (hpd_event && hpd_en_reg)
			pend_next[PSM_PEND_HPD] = 1'b1;
		if (rsense_event && rsense_en_reg && link_en_reg && !in_off)
			pend_next[PSM_PEND_RSENSE] = 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			pend_reg <= 2'h0;
		else
			pend_reg <= pend_next;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			irq_out <= 1'b0;
		else if (in_off)
			irq_out <= irq_out || (pend_next[PSM_PEND_HPD] && hpd_en_reg);
		else
			irq_out <= |(pend_next & {rsense_en_reg, hpd_en_reg});
	end

	// Function enables follow the next state so they change with it.
	always_ff @(posedge core_clk)
	begin
		if (rst)
			enables <= PSM_RST_ENABLES;
		else
		begin
			case (state_next)
				PSM_FULL:
				begin
					enables.av_pipe   <= 1'b1;
					enables.cfg_if    <= 1'b1;
					enables.cec       <= 1'b1;
					enables.gpio      <= 1'b1;
					enables.ddc       <= 1'b1;
					enables.clk_run   <= 1'b1;
					enables.link_core <= wr_ok ? cfg_wdata.link_core_en : link_en_reg;
				end
				PSM_STBY:
				begin
					enables.av_pipe   <= 1'b0;
					enables.cfg_if    <= 1'b1;
					enables.cec       <= 1'b1;
					enables.gpio      <= 1'b1;
					enables.ddc       <= 1'b1;
					enables.clk_run   <= 1'b1;
					enables.link_core <= wr_ok ? cfg_wdata.link_core_en : link_en_reg;
				end
				default:
				begin
					enables <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			state_out <= PSM_RST_STATE;
		else
			state_out <= state_next;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cfg_ack   <= 1'b0;
			cfg_rdata <= '0;
		end
		else
		begin
			cfg_ack <= cfg_req && !in_off;
			if (cfg_req && !cfg_we && !in_off)
			begin
				cfg_rdata.state         <= state_reg;
				cfg_rdata.link_core_en  <= link_en_reg;
				cfg_rdata.hpd_irq_en    <= hpd_en_reg;
				cfg_rdata.rsense_irq_en <= rsense_en_reg;
				cfg_rdata.pend          <= pend_reg;
			end
		end
	end

	// Strap is taken once the synchroniser has settled after reset.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			strap_cnt_reg  <= 2'h0;
			strap_done_reg <= 1'b0;
			slave_addr     <= PSM_ADDR_SEL_LOW;
		end
		else if (!strap_done_reg)
		begin
			strap_cnt_reg <= strap_cnt_reg + 2'h1;
			if (strap_cnt_reg == PSM_STRAP_WAIT)
			begin
				strap_done_reg <= 1'b1;
				slave_addr     <= pins_sync[0] ? PSM_ADDR_SEL_HIGH : PSM_ADDR_SEL_LOW;
			end
		end
	end

endmodule // psm_power_state_manager

/* psm_assertions.sv */
`timescale 1ns/100ps
module psm_assertions
	import psm_pkg::*;
(
	input  wire logic    core_clk,
	input  wire logic    rst,
	input  wire logic    cfg_req,
	input  wire logic    cfg_we,
	input  psm_ctrl_t    cfg_wdata,
	input  wire logic    cfg_ack,
	input  psm_enables_t enables,
	input  psm_state_t   state_out,
	input  wire logic    irq_out
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	wire off = state_out == PSM_OFF;
	wire wr = cfg_req && cfg_we && !off;
	property p_ack; cfg_req && !off |=> cfg_ack; endproperty
	a_ack: assert property (p_ack) else $error("request not acked");
	property p_noack; cfg_req && off |=> !cfg_ack; endproperty
	a_noack: assert property (p_noack) else $error("ack while off");
	property p_sticky; off |=> off; endproperty
	a_sticky: assert property (p_sticky) else $error("left off without reset");
	property p_full; state_out == PSM_FULL |-> (enables | 7'h02) == 7'h7f; endproperty
	a_full: assert property (p_full) else $error("full power enables");
	property p_stby; state_out == PSM_STBY |-> (enables | 7'h02) == 7'h3f; endproperty
	a_stby: assert property (p_stby) else $error("standby enables");
	property p_off_en; off |-> enables == 7'h00; endproperty
	a_off_en: assert property (p_off_en) else $error("off enables");
	property p_irq_hold; off && irq_out |=> irq_out; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped in off");
	property p_wr; wr && cfg_wdata.req_state != 2'h2 |=> state_out == $past(cfg_wdata.req_state);
	endproperty
	a_wr: assert property (p_wr) else $error("state not written");
	property p_link; wr && cfg_wdata.req_state == PSM_STBY
		|=> enables.link_core == $past(cfg_wdata.link_core_en); endproperty
	a_link: assert property (p_link) else $error("link core enable");
	c_stby: cover property (state_out == PSM_STBY);
	c_off_irq: cover property (off && irq_out);
	c_refused: cover property (cfg_req && off);
endmodule // psm_assertions

bind psm_power_state_manager psm_assertions u_chk (.core_clk(core_clk), .rst(rst),
	.cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
	.enables(enables), .state_out(state_out), .irq_out(irq_out));

/* psm_host_model.sv */
`timescale 1ns/100ps
module psm_host_model
	import psm_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic cfg_ack,
	output logic      rst,
	output logic      cfg_req,
	output logic      cfg_we,
	output psm_ctrl_t cfg_wdata
);
	initial
	begin
		rst = 1'b1;
		cfg_req = 1'b0;
		cfg_we = 1'b0;
		cfg_wdata = '0;
	end
	task automatic hw_reset();
		rst = 1'b1;
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
	endtask
	task automatic acc(input logic we, input psm_ctrl_t d, output logic ok);
		@(negedge core_clk);
		cfg_req = 1'b1;
		cfg_we = we;
		cfg_wdata = d;
		@(negedge core_clk);
		ok = cfg_ack;
		cfg_req = 1'b0;
		cfg_we = ~we;
		cfg_wdata = psm_ctrl_t'(~d);
	endtask
endmodule // psm_host_model

/* psm_power_state_manager_tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, a) chk(n, 8'(e), 8'(a))
module psm_power_state_manager_tb_top
	import psm_pkg::*;
;
	logic         core_clk = 1'b0;
	logic         rst, cfg_req, cfg_we, cfg_ack, irq_out, ack;
	logic         sel = 1'b0, hpd = 1'b0, rs = 1'b0;
	int           num_errors = 0, n_checks = 0;
	psm_ctrl_t    wdata;
	psm_status_t  rdata;
	logic [7:0]   addr;
	psm_enables_t en;
	psm_state_t   st;
	always #12.5 core_clk = ~core_clk;
	psm_power_state_manager u_dut (.core_clk(core_clk), .rst(rst), .cfg_req(cfg_req),
		.cfg_we(cfg_we), .cfg_wdata(wdata), .slave_addr_select_pin(sel), .hpd_pin(hpd),
		.rsense_pin(rs), .cfg_ack(cfg_ack), .cfg_rdata(rdata), .slave_addr(addr),
		.enables(en), .state_out(st), .irq_out(irq_out));
	psm_host_model u_host (.core_clk(core_clk), .cfg_ack(cfg_ack), .rst(rst),
		.cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_wdata(wdata));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] a);
		n_checks++;
		if (a !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, a);
			num_errors++;
		end
	endtask
	task automatic wirq();
		for (int i = 0; i < 10 && irq_out !== 1'b1; i++) @(negedge core_clk);
	endtask
	task automatic t_reset();
		repeat (4) @(negedge core_clk);
		`CHK("state", PSM_FULL, st);
		`CHK("enables", 7'h7d, en);
		`CHK("irq", 1'b0, irq_out);
		`CHK("addr", 8'h72, addr);
		$display("t_reset done");
	endtask
	task automatic t_stby();
		u_host.acc(1'b1, 7'h34, ack);
		`CHK("ack", 1'b1, ack);
		`CHK("state", PSM_STBY, st);
		`CHK("enables", 7'h3f, en);
		rs = 1'b1;
		wirq();
		`CHK("irq", 1'b1, irq_out);
		u_host.acc(1'b0, 7'h00, ack);
		`CHK("status", 7'h36, rdata);
		u_host.acc(1'b1, 7'h57, ack);
		@(negedge core_clk);
		`CHK("state", PSM_STBY, st);
		`CHK("irq", 1'b0, irq_out);
		u_host.acc(1'b1, 7'h00, ack);
		`CHK("enables", 7'h7d, en);
		$display("t_stby done");
	endtask
	task automatic t_off();
		u_host.acc(1'b1, 7'h68, ack);
		`CHK("state", PSM_OFF, st);
		`CHK("enables", 7'h00, en);
		u_host.acc(1'b0, 7'h00, ack);
		`CHK("ack", 1'b0, ack);
		hpd = 1'b1;
		wirq();
		`CHK("irq", 1'b1, irq_out);
		u_host.acc(1'b1, 7'h00, ack);
		repeat (20) @(negedge core_clk);
		`CHK("ack", 1'b0, ack);
		`CHK("state", PSM_OFF, st);
		`CHK("irq", 1'b1, irq_out);
		sel = 1'b1;
		u_host.hw_reset();
		repeat (4) @(negedge core_clk);
		`CHK("state", PSM_FULL, st);
		`CHK("irq", 1'b0, irq_out);
		`CHK("addr", 8'h76, addr);
		$display("t_off done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		u_host.hw_reset();
		t_reset();
		t_stby();
		t_off();
		print_verdict();
	end
	// The tests need about 60 cycles; 4000 cycles leaves ample margin.
	initial
	begin
		#100us;
		num_errors++;
		print_verdict();
	end
endmodule // psm_power_state_manager_tb_top
